// [core/host_port_map.svh]
// pin indices, timing figures and reset values of the host port
// assumes nothing; definitions only
`ifndef HOST_PORT_MAP_SVH
`define HOST_PORT_MAP_SVH

// bit positions inside the sampled pin vector
`define PIN_CS        10
`define PIN_RW        9
`define PIN_EN        8
`define PIN_IDLE      11'h7FF

// data bus bits reused by the serial styles
`define BIT_SCLK      0
`define BIT_SERIAL_DATA_IN      1
`define BIT_SDAO      2

`define BYTE_LAST     4'h7
`define BYTE_FIRST    4'h0
`define DATA_ZERO     8'h00
`define DATA_ALL      8'hFF

// host timing, ns, and cycle counts at mclk
`define MCLK_NS       40
`define SETUP_NS      80
`define STROBE_NS     480
`define HOLD_NS       80
`define HALF_NS       400
`define SETUP_CYC     ((`SETUP_NS + `MCLK_NS - 1) / `MCLK_NS)
`define STROBE_CYC    ((`STROBE_NS + `MCLK_NS - 1) / `MCLK_NS)
`define HOLD_CYC      ((`HOLD_NS + `MCLK_NS - 1) / `MCLK_NS)
`define HALF_CYC      ((`HALF_NS + `MCLK_NS - 1) / `MCLK_NS)

// read turnaround outlasts the device's filtered drive
`define TURN_NS       240
`define TURN_CYC      ((`TURN_NS + `MCLK_NS - 1) / `MCLK_NS)

// host drive masks at frame start in the serial styles
`define SER_OE        8'h03
`define I2C_START_OE  8'h02

`endif

// [core/host_port_pkg.sv]
// types shared by both ends of the display host port
// assumes host_port_map.svh supplies the numbers
package host_port_pkg;

  typedef enum logic [1:0] {
    select_enable_bus_mode,
    dual_strobe_bus_mode,
    serial_bus_mode,
    i2c_bus_mode
  } bus_mode_type;

  typedef enum logic [1:0] {
    i2c_idle,
    i2c_bits,
    i2c_ack_wait,
    i2c_ack
  } i2c_state_type;

  typedef enum logic [3:0] {
    h_idle,
    h_setup,
    h_strobe,
    h_hold,
    h_start,
    h_bit_lo,
    h_bit_hi,
    h_ack_lo,
    h_ack_hi,
    h_stop_lo,
    h_stop_hi
  } host_phase_type;

  typedef struct packed {
    logic [10:0]   s1;
    logic [10:0]   s2;
    logic [10:0]   s3;
    logic [10:0]   flt;
    logic [10:0]   prv;
    bus_mode_type  mode;
    i2c_state_type ist;
    logic [7:0]    shift;
    logic [3:0]    cnt;
    logic [7:0]    wr_data;
    logic          wr_valid;
    logic          rd_req;
    logic [7:0]    dout;
    logic          dout_oe;
    logic          sda_low;
  } dev_state_type;

  typedef struct packed {
    host_phase_type phase;
    logic [7:0]     timer;
    logic [3:0]     bitn;
    logic [7:0]     shift;
    logic           is_read;
    logic           cs_n;
    logic           rw;
    logic           en;
    logic [7:0]     dout;
    logic [7:0]     doe;
    logic [7:0]     s1;
    logic [7:0]     s2;
    logic [7:0]     s3;
    logic [7:0]     flt;
    logic           rd_valid;
    logic [7:0]     rd_data;
  } host_state_type;

endpackage

// [core/host_port_if.sv]
// pins between the display host port and its host
// assumes a pull-up on every data line; bits 1 and 2 tied in i2c
`timescale 1ns/1ps
`default_nettype none

interface host_port_if;
  logic       cs_n;
  logic       rw_pin;
  logic       en_pin;
  logic [7:0] host_d_o;
  logic [7:0] host_d_oe;
  logic [7:0] dev_d_o;
  logic [7:0] dev_d_oe;
  logic       i2c_tie;
  logic [7:0] raw;
  logic       sda;
  logic [7:0] data_line;

  // wire resolution, pull-up when nobody drives
  assign raw = (dev_d_oe & dev_d_o) | (~dev_d_oe & host_d_oe & host_d_o) | (~dev_d_oe & ~host_d_oe);
  assign sda = raw[1] & raw[2];
  assign data_line = i2c_tie ? {raw[7:3], sda, sda, raw[0]} : raw;

  modport device (
    input  cs_n,
    input  rw_pin,
    input  en_pin,
    input  data_line,
    output dev_d_o,
    output dev_d_oe
  );

  modport host (
    output cs_n,
    output rw_pin,
    output en_pin,
    output host_d_o,
    output host_d_oe,
    output i2c_tie,
    input  data_line
  );
endinterface

`default_nettype wire

// [core/display_host_bus_port.sv]
// device end of the display host port: four bus styles on one pin set
// assumes the host keeps each style's strobes; mode strapped during srst
//
// How it works
// - select-enable: rw pin high reads, low writes
// - dual-strobe: rw pin is active-low write strobe
// - select-enable: enable high with select starts transfer
// - dual-strobe: enable pin is active-low read strobe
// - eight-bit data bus, driven only during reads, apart from the i2c ack on bit 2
// - serial: bit 1 data in, bit 0 clock
// - i2c: bit 2 sda out, bit 1 in, bit 0 scl
`timescale 1ns/1ps
`default_nettype none
`include "host_port_map.svh"

module display_host_bus_port (
  input  wire logic                        mclk,
  input  wire logic                        srst,
  input  wire host_port_pkg::bus_mode_type mode,
  input  wire logic [7:0]                  rd_data,
  output logic                             rd_req,
  output logic                             wr_valid,
  output logic [7:0]                       wr_data,
  host_port_if.device                      bus
);
  import host_port_pkg::*;

  dev_state_type s_q;
  dev_state_type s_d;
  logic          sel;
  logic          sel_p;
  logic          rw;
  logic          rw_p;
  logic          en;
  logic          en_p;
  logic          act;
  logic          act_p;
  logic          wr_act;
  logic          wr_act_p;
  logic          sclk;
  logic          sclk_p;
  logic          serial_data_in;
  logic          serial_data_in_p;
  logic          clk_rise;
  logic          clk_fall;
  logic          i2c_start;
  logic          i2c_stop;
  logic [10:0]   pins;

  ////////////////////////////////////////////////////////////////////////////
  // raw pin vector, chip select on top
  assign pins = {bus.cs_n, bus.rw_pin, bus.en_pin, bus.data_line};

  ////////////////////////////////////////////////////////////////////////////
  // filtered pin views
  assign sel    = ~s_q.flt[`PIN_CS];
  assign sel_p  = ~s_q.prv[`PIN_CS];
  assign rw     = s_q.flt[`PIN_RW];
  assign rw_p   = s_q.prv[`PIN_RW];
  assign en     = s_q.flt[`PIN_EN];
  assign en_p   = s_q.prv[`PIN_EN];
  assign sclk   = s_q.flt[`BIT_SCLK];
  assign sclk_p = s_q.prv[`BIT_SCLK];
  assign serial_data_in   = s_q.flt[`BIT_SERIAL_DATA_IN];
  assign serial_data_in_p = s_q.prv[`BIT_SERIAL_DATA_IN];
  assign clk_rise = sclk & ~sclk_p;
  assign clk_fall = ~sclk & sclk_p;

  ////////////////////////////////////////////////////////////////////////////
  // i2c start and stop: sda moving while scl high
  assign i2c_start = sclk & sclk_p & serial_data_in_p & ~serial_data_in;
  assign i2c_stop  = sclk & sclk_p & ~serial_data_in_p & serial_data_in;

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    s_d = s_q;
    act = 1'b0;
    act_p = 1'b0;
    wr_act = 1'b0;
    wr_act_p = 1'b0;
    // three-flop sampling, change taken once second and third agree
    s_d.s1 = pins;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    s_d.flt = (s_q.s2 & ~(s_q.s2 ^ s_q.s3)) | (s_q.flt & (s_q.s2 ^ s_q.s3));
    s_d.prv = s_q.flt;
    s_d.wr_valid = 1'b0;
    s_d.rd_req = 1'b0;

    unique case (s_q.mode)
      select_enable_bus_mode: begin
        act   = sel & en;
        act_p = sel_p & en_p;
        if (act && rw && !act_p) begin
          s_d.dout = rd_data;
          s_d.rd_req = 1'b1;
        end
        s_d.dout_oe = act & rw;
        if (act_p && !act && !rw_p) begin
          s_d.wr_data = s_q.prv[7:0];
          s_d.wr_valid = 1'b1;
        end
      end
      dual_strobe_bus_mode: begin
        act      = sel & ~en;
        act_p    = sel_p & ~en_p;
        wr_act   = sel & ~rw;
        wr_act_p = sel_p & ~rw_p;
        if (act && !act_p) begin
          s_d.dout = rd_data;
          s_d.rd_req = 1'b1;
        end
        s_d.dout_oe = act;
        if (wr_act_p && !wr_act) begin
          s_d.wr_data = s_q.prv[7:0];
          s_d.wr_valid = 1'b1;
        end
      end
      serial_bus_mode: begin
        s_d.dout_oe = 1'b0;
        if (!sel) begin
          s_d.cnt = `BYTE_FIRST;
        end else if (clk_rise) begin
          s_d.shift = {s_q.shift[6:0], serial_data_in};
          s_d.cnt = s_q.cnt + 4'h1;
          if (s_q.cnt == `BYTE_LAST) begin
            s_d.wr_data = {s_q.shift[6:0], serial_data_in};
            s_d.wr_valid = 1'b1;
            s_d.cnt = `BYTE_FIRST;
          end
        end
      end
      i2c_bus_mode: begin
        s_d.dout_oe = 1'b0;
        if (i2c_start) begin
          s_d.ist = i2c_bits;
          s_d.cnt = `BYTE_FIRST;
          s_d.sda_low = 1'b0;
        end else if (i2c_stop) begin
          s_d.ist = i2c_idle;
          s_d.sda_low = 1'b0;
        end else begin
          unique case (s_q.ist)
            i2c_idle: begin
              s_d.sda_low = 1'b0;
            end
            i2c_bits: begin
              if (clk_rise) begin
                s_d.shift = {s_q.shift[6:0], serial_data_in};
                s_d.cnt = s_q.cnt + 4'h1;
                if (s_q.cnt == `BYTE_LAST) begin
                  s_d.wr_data = {s_q.shift[6:0], serial_data_in};
                  s_d.wr_valid = 1'b1;
                  s_d.ist = i2c_ack_wait;
                end
              end
            end
            i2c_ack_wait: begin
              if (clk_fall) begin
                s_d.sda_low = 1'b1;
                s_d.ist = i2c_ack;
              end
            end
            i2c_ack: begin
              if (clk_fall) begin
                s_d.sda_low = 1'b0;
                s_d.cnt = `BYTE_FIRST;
                s_d.ist = i2c_bits;
              end
            end
          endcase
        end
      end
    endcase

    // style strapped only while reset is held
    if (srst) begin
      s_d = '0;
      s_d.s1 = `PIN_IDLE;
      s_d.s2 = `PIN_IDLE;
      s_d.s3 = `PIN_IDLE;
      s_d.flt = `PIN_IDLE;
      s_d.prv = `PIN_IDLE;
      s_d.mode = mode;
      s_d.ist = i2c_idle;
    end
  end

  always_ff @(posedge mclk) begin
    s_q <= s_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  always_comb begin
    bus.dev_d_o  = s_q.dout;
    bus.dev_d_oe = s_q.dout_oe ? `DATA_ALL : `DATA_ZERO;
    if (s_q.mode == i2c_bus_mode) begin
      bus.dev_d_o  = `DATA_ZERO;
      bus.dev_d_oe = `DATA_ZERO;
      bus.dev_d_oe[`BIT_SDAO] = s_q.sda_low;
    end
  end

  assign rd_req   = s_q.rd_req;
  assign wr_valid = s_q.wr_valid;
  assign wr_data  = s_q.wr_data;
endmodule

`default_nettype wire

// [core/display_host_master.sv]
// host end of the display host port: one byte per command
// assumes the device latches its style at reset; serial styles write only
`timescale 1ns/1ps
`default_nettype none
`include "host_port_map.svh"

module display_host_master (
  input  wire logic                        mclk,
  input  wire logic                        srst,
  input  wire host_port_pkg::bus_mode_type mode,
  input  wire logic                        cmd_valid,
  input  wire logic                        cmd_write,
  input  wire logic [7:0]                  cmd_data,
  output logic                             cmd_ready,
  output logic                             rd_valid,
  output logic [7:0]                       rd_data,
  host_port_if.host                        bus
);
  import host_port_pkg::*;

  host_state_type h_q;
  host_state_type h_d;
  logic           se;
  logic           i2c;
  logic           tdone;

  assign se    = (mode == select_enable_bus_mode);
  assign i2c   = (mode == i2c_bus_mode);
  assign tdone = (h_q.timer == 8'h00);

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    h_d = h_q;
    h_d.s1 = bus.data_line;
    h_d.s2 = h_q.s1;
    h_d.s3 = h_q.s2;
    h_d.flt = (h_q.s2 & ~(h_q.s2 ^ h_q.s3)) | (h_q.flt & (h_q.s2 ^ h_q.s3));
    h_d.rd_valid = 1'b0;
    if (!tdone) begin
      h_d.timer = h_q.timer - 8'h01;
    end
    unique case (h_q.phase)
      h_idle: begin
        if (cmd_valid) begin
          h_d.shift = cmd_data;
          h_d.bitn = `BYTE_FIRST;
          h_d.is_read = ~cmd_write;
          h_d.cs_n = 1'b0;
          if (mode == serial_bus_mode) begin
            h_d.doe = `SER_OE;
            h_d.dout = `DATA_ZERO;
            h_d.phase = h_bit_lo;
            h_d.timer = 8'(`HALF_CYC);
          end else if (i2c) begin
            h_d.doe = `I2C_START_OE;
            h_d.dout = `DATA_ZERO;
            h_d.phase = h_start;
            h_d.timer = 8'(`HALF_CYC);
          end else begin
            h_d.rw = se ? ~cmd_write : 1'b1;
            h_d.en = ~se;
            h_d.dout = cmd_data;
            h_d.doe = cmd_write ? `DATA_ALL : `DATA_ZERO;
            h_d.phase = h_setup;
            h_d.timer = 8'(`SETUP_CYC);
          end
        end
      end
      h_setup: begin
        if (tdone) begin
          if (se) begin
            h_d.en = 1'b1;
          end else if (h_q.is_read) begin
            h_d.en = 1'b0;
          end else begin
            h_d.rw = 1'b0;
          end
          h_d.phase = h_strobe;
          h_d.timer = 8'(`STROBE_CYC);
        end
      end
      h_strobe: begin
        if (tdone) begin
          if (h_q.is_read) begin
            h_d.rd_data = h_q.flt;
            h_d.rd_valid = 1'b1;
          end
          h_d.en = ~se;
          h_d.rw = se ? h_q.rw : 1'b1;
          h_d.phase = h_hold;
          // reads wait out the device's lagging drive
          h_d.timer = h_q.is_read ? 8'(`TURN_CYC) : 8'(`HOLD_CYC);
        end
      end
      h_hold: begin
        if (tdone) begin
          h_d.cs_n = 1'b1;
          h_d.rw = 1'b1;
          h_d.doe = `DATA_ZERO;
          h_d.phase = h_idle;
        end
      end
      h_start: begin
        if (tdone) begin
          h_d.doe[`BIT_SCLK] = 1'b1;
          h_d.phase = h_bit_lo;
          h_d.timer = 8'(`HALF_CYC);
        end
      end
      h_bit_lo: begin
        h_d.dout[`BIT_SERIAL_DATA_IN] = i2c ? 1'b0 : h_q.shift[7];
        h_d.doe[`BIT_SERIAL_DATA_IN]  = i2c ? ~h_q.shift[7] : 1'b1;
        if (tdone) begin
          h_d.dout[`BIT_SCLK] = 1'b1;
          h_d.doe[`BIT_SCLK] = ~i2c;
          h_d.phase = h_bit_hi;
          h_d.timer = 8'(`HALF_CYC);
        end
      end
      h_bit_hi: begin
        if (tdone) begin
          h_d.dout[`BIT_SCLK] = 1'b0;
          h_d.doe[`BIT_SCLK] = 1'b1;
          h_d.shift = {h_q.shift[6:0], 1'b0};
          h_d.bitn = h_q.bitn + 4'h1;
          h_d.timer = 8'(`HALF_CYC);
          if (h_q.bitn != `BYTE_LAST) begin
            h_d.phase = h_bit_lo;
          end else if (i2c) begin
            h_d.doe[`BIT_SERIAL_DATA_IN] = 1'b0;
            h_d.phase = h_ack_lo;
          end else begin
            h_d.phase = h_hold;
          end
        end
      end
      h_ack_lo: begin
        if (tdone) begin
          h_d.doe[`BIT_SCLK] = 1'b0;
          h_d.phase = h_ack_hi;
          h_d.timer = 8'(`HALF_CYC);
        end
      end
      h_ack_hi: begin
        if (tdone) begin
          h_d.doe[`BIT_SCLK] = 1'b1;
          h_d.doe[`BIT_SERIAL_DATA_IN] = 1'b1;
          h_d.phase = h_stop_lo;
          h_d.timer = 8'(`HALF_CYC);
        end
      end
      h_stop_lo: begin
        if (tdone) begin
          h_d.doe[`BIT_SCLK] = 1'b0;
          h_d.phase = h_stop_hi;
          h_d.timer = 8'(`HALF_CYC);
        end
      end
      h_stop_hi: begin
        if (tdone) begin
          h_d.doe[`BIT_SERIAL_DATA_IN] = 1'b0;
          h_d.phase = h_hold;
          h_d.timer = 8'(`HOLD_CYC);
        end
      end
      default: begin
        h_d.phase = h_idle;
      end
    endcase
    if (srst) begin
      h_d = '0;
      h_d.phase = h_idle;
      h_d.cs_n = 1'b1;
      h_d.rw = 1'b1;
      h_d.en = 1'b1;
      h_d.s1 = `DATA_ALL;
      h_d.s2 = `DATA_ALL;
      h_d.s3 = `DATA_ALL;
      h_d.flt = `DATA_ALL;
    end
  end

  always_ff @(posedge mclk) begin
    h_q <= h_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign cmd_ready     = (h_q.phase == h_idle) & ~srst;
  assign rd_valid      = h_q.rd_valid;
  assign rd_data       = h_q.rd_data;
  assign bus.cs_n      = h_q.cs_n;
  assign bus.rw_pin    = h_q.rw;
  assign bus.en_pin    = h_q.en;
  assign bus.host_d_o  = h_q.dout;
  assign bus.host_d_oe = h_q.doe;
  assign bus.i2c_tie   = i2c;
endmodule

`default_nettype wire

// [tb/host_port_properties.sv]
// pin-level checks on the host port between both ends
// assumes one mclk domain, srst synchronous active high
`timescale 1ns/1ps
`default_nettype none

module host_port_properties (
  input wire logic                        mclk,
  input wire logic                        srst,
  input wire host_port_pkg::bus_mode_type mode,
  input wire logic                        cs_n,
  input wire logic                        rw_pin,
  input wire logic                        en_pin,
  input wire logic [7:0]                  host_d_oe,
  input wire logic [7:0]                  dev_d_oe,
  input wire logic                        i2c_tie
);
  import host_port_pkg::*;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  ////////////////////////////////////////////////////////////////////////////
  sel_write_a: assert property (mode == select_enable_bus_mode && !cs_n && en_pin && !rw_pin
    |-> host_d_oe == 8'hFF) else $error("host not driving a select-enable write");
  sel_read_a: assert property (mode == select_enable_bus_mode && !cs_n && en_pin && rw_pin
    |-> host_d_oe == 8'h00) else $error("host driving during a select-enable read");
  en_start_a: assert property (mode == select_enable_bus_mode && $rose(en_pin) |-> !cs_n)
    else $error("enable raised without chip select");
  en_length_a: assert property (mode == select_enable_bus_mode && $rose(en_pin) |-> en_pin [*8])
    else $error("enable pulse too short");
  sel_answer_a: assert property (mode == select_enable_bus_mode && $rose(en_pin) && rw_pin
    |-> ##[1:8] dev_d_oe == 8'hFF) else $error("device silent on select-enable read");
  wr_strobe_a: assert property (mode == dual_strobe_bus_mode && !cs_n && !rw_pin
    |-> host_d_oe == 8'hFF && dev_d_oe == 8'h00) else $error("bad drive under write strobe");
  rd_strobe_a: assert property (mode == dual_strobe_bus_mode && $fell(en_pin)
    |-> !cs_n ##[1:8] dev_d_oe == 8'hFF) else $error("read strobe not answered");
  no_clash_a: assert property ((mode == select_enable_bus_mode || mode == dual_strobe_bus_mode)
    && dev_d_oe != 8'h00 |-> host_d_oe == 8'h00 && dev_d_oe == 8'hFF) else $error("data bus clash");
  serial_pins_a: assert property (mode == serial_bus_mode
    |-> dev_d_oe == 8'h00 && host_d_oe[7:2] == 6'h00) else $error("wrong pins in serial style");
  i2c_pins_a: assert property (mode == i2c_bus_mode
    |-> dev_d_oe[7:3] == 5'h00 && dev_d_oe[1:0] == 2'h0 && i2c_tie) else $error("wrong pins in i2c style");
  tie_mode_a: assert property (i2c_tie |-> mode == i2c_bus_mode)
    else $error("sda tie outside i2c style");
endmodule

`default_nettype wire

// [tb/display_host_bus_port_test.sv]
// self-checking bench: host end and device end joined by the pin interface
// assumes the design files under core/ are compiled first
`timescale 1ns/1ps
`default_nettype none

`define CHK(what, exp, got) begin n_checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("[ERR] %s expected %0h seen %0h", what, exp, got); end end

module display_host_bus_port_test;
  import host_port_pkg::*;

  logic         mclk;
  logic         srst;
  bus_mode_type mode;
  logic         cmd_valid;
  logic         cmd_write;
  logic [7:0]   cmd_data;
  logic         cmd_ready;
  logic         host_rd_valid;
  logic [7:0]   host_rd;
  logic [7:0]   dev_rd;
  logic         rd_req;
  logic         wr_valid;
  logic [7:0]   wr_data;
  logic         seen_req;
  logic         seen_ack;
  logic         sclk_q;
  logic         en_q;
  logic         rw_q;
  logic [7:0]   wire_byte;
  int           seed;
  int           num_errors;
  int           n_checks;
  logic [7:0]   corner [3] = '{8'h00, 8'hFF, 8'h81};

  host_port_if u_host_port_if ();

  display_host_bus_port u_display_host_bus_port (
    .mclk     (mclk),
    .srst     (srst),
    .mode     (mode),
    .rd_data  (dev_rd),
    .rd_req   (rd_req),
    .wr_valid (wr_valid),
    .wr_data  (wr_data),
    .bus      (u_host_port_if.device)
  );

  display_host_master u_display_host_master (
    .mclk      (mclk),
    .srst      (srst),
    .mode      (mode),
    .cmd_valid (cmd_valid),
    .cmd_write (cmd_write),
    .cmd_data  (cmd_data),
    .cmd_ready (cmd_ready),
    .rd_valid  (host_rd_valid),
    .rd_data   (host_rd),
    .bus       (u_host_port_if.host)
  );

  host_port_properties u_host_port_properties (
    .mclk      (mclk),
    .srst      (srst),
    .mode      (mode),
    .cs_n      (u_host_port_if.cs_n),
    .rw_pin    (u_host_port_if.rw_pin),
    .en_pin    (u_host_port_if.en_pin),
    .host_d_oe (u_host_port_if.host_d_oe),
    .dev_d_oe  (u_host_port_if.dev_d_oe),
    .i2c_tie   (u_host_port_if.i2c_tie)
  );

  ////////////////////////////////////////////////////////////////////////////
  always #20 mclk = ~mclk;

  // wire monitor: byte as seen on the pins
  always @(posedge mclk) begin
    sclk_q <= u_host_port_if.data_line[0];
    en_q <= u_host_port_if.en_pin;
    rw_q <= u_host_port_if.rw_pin;
    if (rd_req === 1'b1) seen_req <= 1'b1;
    // sda low under high scl while the host has let go: the device's ack
    if (mode == i2c_bus_mode && u_host_port_if.data_line[0] && !u_host_port_if.data_line[1]
        && !u_host_port_if.host_d_oe[1])
      seen_ack <= 1'b1;
    if (mode == serial_bus_mode && !u_host_port_if.cs_n && !sclk_q && u_host_port_if.data_line[0])
      wire_byte <= {wire_byte[6:0], u_host_port_if.data_line[1]};
    if (mode == select_enable_bus_mode && en_q && !u_host_port_if.en_pin && !u_host_port_if.rw_pin)
      wire_byte <= u_host_port_if.data_line;
    if (mode == dual_strobe_bus_mode && !rw_q && u_host_port_if.rw_pin && !u_host_port_if.cs_n)
      wire_byte <= u_host_port_if.data_line;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic do_reset(input bus_mode_type m);
    srst = 1'b1;
    mode = m;
    repeat (4) @(negedge mclk);
    srst = 1'b0;
  endtask

  task automatic issue(input logic w, input logic [7:0] d);
    int t;
    t = 0;
    while (cmd_ready !== 1'b1 && t < 1000) begin
      @(negedge mclk);
      t++;
    end
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_data = d;
    @(negedge mclk);
    cmd_valid = 1'b0;
  endtask

  task automatic do_write(input logic [7:0] d);
    int t;
    t = 0;
    seen_ack = 1'b0;
    issue(1'b1, d);
    while (wr_valid !== 1'b1 && t < 1000) begin
      @(negedge mclk);
      t++;
    end
    `CHK("wr_valid", 1'b1, wr_valid)
    `CHK("wr_data", d, wr_data)
    if (mode != i2c_bus_mode) `CHK("wire_byte", d, wire_byte)
    while (mode == i2c_bus_mode && cmd_ready !== 1'b1 && t < 2000) begin
      @(negedge mclk);
      t++;
    end
    if (mode == i2c_bus_mode) `CHK("ack", 1'b1, seen_ack)
  endtask

  task automatic do_read(input logic [7:0] d);
    int t;
    t = 0;
    dev_rd = d;
    seen_req = 1'b0;
    issue(1'b0, 8'h00);
    while (host_rd_valid !== 1'b1 && t < 1000) begin
      @(negedge mclk);
      t++;
    end
    `CHK("rd_valid", 1'b1, host_rd_valid)
    `CHK("rd_data", d, host_rd)
    `CHK("rd_req", 1'b1, seen_req)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h2810;
    mclk = 1'b0;
    srst = 1'b1;
    mode = select_enable_bus_mode;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_data = 8'h00;
    dev_rd = 8'h00;
    seen_req = 1'b0;
    wire_byte = 8'h00;
    seen_ack = 1'b0;
    @(negedge mclk);
    for (int m = 0; m < 4; m++) begin
      do_reset(bus_mode_type'(m));
      foreach (corner[i]) do_write(corner[i]);
      for (int i = 0; i < 4; i++) begin
        do_write(8'($random(seed)));
        if (m < 2) do_read(8'($random(seed)));
      end
      if (m < 2) do_read(8'hFF);
      if (m < 2) do_read(8'h00);
    end
    summarize();
  end

  initial begin
    #(40 * 50000);
    num_errors++;
    summarize();
  end
endmodule

`default_nettype wire
